// ### dma_duty_model.sv
// DMA stand-in streaming duty words 16'h1000 + n
// Assumes a valid/ready handshake sampled on the rising edge
`timescale 1ns/10ps
module dma_duty_model (
    // Clock and reset
    input wire i_clk,
    input wire i_srst,
    // Flow control
    input wire i_stall,
    input wire i_duty_ready,
    // Duty stream
    output reg o_duty_valid,
    output reg [15:0] o_duty_data
);
    reg [15:0] next_reg;
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_duty_valid <= 1'b0;
            o_duty_data <= 16'hffff;
            next_reg <= 16'h1000;
        end else if (o_duty_valid && i_duty_ready) begin
            o_duty_valid <= 1'b0;
            o_duty_data <= ~o_duty_data;
            next_reg <= next_reg + 16'h1;
        end else if (!o_duty_valid && !i_stall) begin
            o_duty_valid <= 1'b1;
            o_duty_data <= next_reg;
        end
    end
endmodule

// ### pwm_flag_bit.v
// Sticky status flag with set-over-clear priority
// Assumes set and clear are single-cycle synchronous strobes
`timescale 1ns/10ps
module pwm_flag_bit (
    // Clock and reset
    input wire i_clk,
    input wire i_srst,
    // Control
    input wire i_set,
    input wire i_clr,
    // Flag
    output reg o_flag
);
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule

// ### pwm_sync_auto_consts.vh
// Constants for the automatic synchronous duty update block
// Assumes one 200 MHz clock and plain control ports, no register bus
// Contract
// - With unlock set, period and dead-time apply at next PWM period start.
// - Without unlock, period and dead-time stay at current values.
// - Unlock stays one after write until update, then reads zero.
// - Duty and update-period values apply automatically at update period end.
// - Update period lasts update_period_count plus one synchronous PWM periods.
// - Write-ready flag sets when ready, clears on second status read; the block clears it on the first status read.
// - Write-ready and DMA request at period end or chosen compare match.
// - Underrun sets when period ends before all duties written; clears on read.
// - Interrupt from each flag only when its mask bit is enabled.
// - Software waits write-ready; new update period applies after period end.
`ifndef PWM_SYNC_AUTO_CONSTS_VH
`define PWM_SYNC_AUTO_CONSTS_VH
`define NUM_CH 4
`define DUTY_W 16
`define PERIOD_W 16
`define DT_W 16
`define UPDATE_PERIOD_W 4
`define CMP_SEL_W 3
`define NUM_CMP 8
`define METHOD_W 2
`define METHOD_AUTO 2'h2
`define IDX_W 2
`endif

// ### pwm_sync_auto_sva.sv
// Port assertions for the synchronous auto-update block
// Assumes one clock and a synchronous high reset
`timescale 1ns/10ps
module pwm_sync_auto_sva (
    // Clock and reset
    input wire i_clk,
    input wire i_srst,
    // Watched inputs
    input wire i_period_start,
    input wire i_unlock_wr,
    input wire i_status_rd,
    input wire [7:0] i_compare_match,
    input wire [1:0] i_second_irq_mask,
    // Watched outputs
    input wire o_duty_ready,
    input wire o_dma_request,
    input wire o_update_unlock,
    input wire o_write_ready_flag,
    input wire o_update_underrun_flag,
    input wire o_irq,
    input wire [15:0] o_period,
    input wire [15:0] o_dead_time
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_unlock_kept: assert property ((i_unlock_wr || o_update_unlock) && !(i_period_start && o_update_unlock)
        |=> o_update_unlock) else $error("unlock lost");
    a_unlock_apply: assert property (o_update_unlock && i_period_start |=> !o_update_unlock)
        else $error("unlock kept");
    a_locked_stable: assert property (!o_update_unlock |=> $stable(o_period) && $stable(o_dead_time))
        else $error("locked value moved");
    a_read_clears: assert property (i_status_rd && !i_period_start && i_compare_match == 8'h00
        |=> !o_write_ready_flag && !o_update_underrun_flag) else $error("flags kept");
    a_ready_cause: assert property ($rose(o_write_ready_flag)
        |-> $past(i_period_start) || $past(i_compare_match) != 8'h00) else $error("ready without cause");
    a_under_cause: assert property ($rose(o_update_underrun_flag) |-> $past(i_period_start))
        else $error("underrun without end");
    a_irq_masked: assert property (o_irq == ((o_write_ready_flag && i_second_irq_mask[0])
        || (o_update_underrun_flag && i_second_irq_mask[1]))) else $error("irq mask");
    a_request_gate: assert property (o_dma_request == (o_write_ready_flag && o_duty_ready))
        else $error("request");
endmodule
bind pwm_sync_auto_update pwm_sync_auto_sva chk_u (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_period_start(i_period_start),
    .i_unlock_wr(i_unlock_wr),
    .i_status_rd(i_status_rd),
    .i_compare_match(i_compare_match),
    .i_second_irq_mask(i_second_irq_mask),
    .o_duty_ready(o_duty_ready),
    .o_dma_request(o_dma_request),
    .o_update_unlock(o_update_unlock),
    .o_write_ready_flag(o_write_ready_flag),
    .o_update_underrun_flag(o_update_underrun_flag),
    .o_irq(o_irq),
    .o_period(o_period),
    .o_dead_time(o_dead_time)
);

// ### pwm_sync_auto_update.v
// Automatic duty and update-period refresh for synchronous PWM channels
// Assumes a period-start pulse from the counter, a DMA duty stream, processor shadows
`timescale 1ns/10ps
`include "pwm_sync_auto_consts.vh"
module pwm_sync_auto_update (
    // Clock and reset
    input wire i_clk,
    input wire i_srst,
    // Configuration
    input wire [`METHOD_W-1:0] i_sync_update_method,
    input wire [`NUM_CH-1:0] i_channel_sync_select,
    input wire i_channel_zero_enable,
    input wire i_request_trigger_mode,
    input wire [`CMP_SEL_W-1:0] i_request_compare_select,
    input wire [`NUM_CMP-1:0] i_compare_match,
    // PWM timing
    input wire i_period_start,
    // Processor shadow writes
    input wire i_period_wr,
    input wire [`PERIOD_W-1:0] i_period_wdata,
    input wire i_dead_time_wr,
    input wire [`DT_W-1:0] i_dead_time_wdata,
    input wire i_update_period_wr,
    input wire [`UPDATE_PERIOD_W-1:0] i_update_period_wdata,
    input wire i_unlock_wr,
    // Status read and mask
    input wire i_status_rd,
    input wire [1:0] i_second_irq_mask,
    // DMA duty stream
    input wire i_duty_valid,
    input wire [`DUTY_W-1:0] i_duty_data,
    output wire o_duty_ready,
    output wire o_dma_request,
    // Applied values
    output reg [`NUM_CH*`DUTY_W-1:0] o_duty,
    output reg [`PERIOD_W-1:0] o_period,
    output reg [`DT_W-1:0] o_dead_time,
    output reg [`UPDATE_PERIOD_W-1:0] o_update_period_count,
    // Status
    output wire o_update_unlock,
    output wire o_write_ready_flag,
    output wire o_update_underrun_flag,
    output wire o_irq
);
    reg [`PERIOD_W-1:0] period_shadow_reg;
    reg [`DT_W-1:0] dead_time_shadow_reg;
    reg [`UPDATE_PERIOD_W-1:0] update_period_shadow_reg;
    reg unlock_reg;
    reg running_reg;
    reg [`UPDATE_PERIOD_W-1:0] per_cnt_reg;
    reg [`UPDATE_PERIOD_W-1:0] per_cnt_next;
    reg [`NUM_CH-1:0] pending_reg;
    reg [`NUM_CH-1:0] pending_next;
    wire [`NUM_CH-1:0] first_oh;
    wire [`NUM_CH:0] lower_pending;
    wire [`NUM_CH*`DUTY_W-1:0] duty_shadow_all;
    wire pending_any;
    wire active;
    wire upd_end;
    wire cmp_hit;
    wire req_evt;
    wire accept;
    wire under_evt;
    wire apply_fixed;
    genvar g;

    // Acts only in the automatic method once started
    assign active = (i_sync_update_method == `METHOD_AUTO) && running_reg;
    assign pending_any = (pending_reg != {`NUM_CH{1'b0}});
    assign upd_end = active && i_period_start && (per_cnt_reg == o_update_period_count);
    assign cmp_hit = i_compare_match[i_request_compare_select];
    assign req_evt = active && (i_request_trigger_mode ? cmp_hit : upd_end);
    assign under_evt = upd_end && pending_any;
    assign apply_fixed = unlock_reg && i_period_start;
    // Word handshake
    assign accept = i_duty_valid && o_duty_ready;

    assign o_duty_ready = active && pending_any;
    assign o_dma_request = o_write_ready_flag && o_duty_ready;
    assign o_update_unlock = unlock_reg;

    // Lowest pending channel takes the next word
    assign lower_pending[0] = 1'b0;
    generate
        for (g = 0; g < `NUM_CH; g = g + 1) begin : gen_chan
            reg [`DUTY_W-1:0] duty_shadow_reg;
            assign first_oh[g] = pending_reg[g] && !lower_pending[g];
            assign lower_pending[g + 1] = lower_pending[g] || pending_reg[g];
            assign duty_shadow_all[g*`DUTY_W +: `DUTY_W] = duty_shadow_reg;

            always @(posedge i_clk) begin
                if (i_srst) begin
                    duty_shadow_reg <= {`DUTY_W{1'b0}};
                end else if (accept && first_oh[g]) begin
                    duty_shadow_reg <= i_duty_data;
                end
            end
        end
    endgenerate

    // Started by channel zero enable, stopped only by reset
    always @(posedge i_clk) begin
        if (i_srst) begin
            running_reg <= 1'b0;
        end else if (i_channel_zero_enable) begin
            running_reg <= 1'b1;
        end
    end

    always @* begin
        per_cnt_next = per_cnt_reg;
        if (!active) begin
            per_cnt_next = {`UPDATE_PERIOD_W{1'b0}};
        end else if (upd_end) begin
            per_cnt_next = {`UPDATE_PERIOD_W{1'b0}};
        end else if (i_period_start) begin
            per_cnt_next = per_cnt_reg + {{(`UPDATE_PERIOD_W-1){1'b0}}, 1'b1};
        end
    end

    // Period counter register
    always @(posedge i_clk) begin
        if (i_srst) begin
            per_cnt_reg <= {`UPDATE_PERIOD_W{1'b0}};
        end else begin
            per_cnt_reg <= per_cnt_next;
        end
    end

    // Refill pending mask at update end
    always @* begin
        pending_next = pending_reg;
        if (upd_end || !active) begin
            pending_next = i_channel_sync_select;
        end else if (accept) begin
            pending_next = pending_reg & ~first_oh;
        end
    end

    // Pending mask register
    always @(posedge i_clk) begin
        if (i_srst) begin
            pending_reg <= {`NUM_CH{1'b0}};
        end else begin
            pending_reg <= pending_next;
        end
    end

    // Processor shadow writes
    always @(posedge i_clk) begin
        if (i_srst) begin
            period_shadow_reg <= {`PERIOD_W{1'b0}};
            dead_time_shadow_reg <= {`DT_W{1'b0}};
            update_period_shadow_reg <= {`UPDATE_PERIOD_W{1'b0}};
        end else begin
            if (i_period_wr) begin
                period_shadow_reg <= i_period_wdata;
            end
            if (i_dead_time_wr) begin
                dead_time_shadow_reg <= i_dead_time_wdata;
            end
            if (i_update_period_wr) begin
                update_period_shadow_reg <= i_update_period_wdata;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            unlock_reg <= 1'b0;
            o_period <= {`PERIOD_W{1'b0}};
            o_dead_time <= {`DT_W{1'b0}};
        end else if (apply_fixed) begin
            o_period <= period_shadow_reg;
            o_dead_time <= dead_time_shadow_reg;
            unlock_reg <= 1'b0;
        end else if (i_unlock_wr) begin
            unlock_reg <= 1'b1;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            o_duty <= {`NUM_CH*`DUTY_W{1'b0}};
            o_update_period_count <= {`UPDATE_PERIOD_W{1'b0}};
        end else if (upd_end) begin
            o_duty <= duty_shadow_all;
            // New update period after elapsed period
            o_update_period_count <= update_period_shadow_reg;
        end
    end

    pwm_flag_bit u_write_ready (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_set(req_evt),
        .i_clr(i_status_rd),
        .o_flag(o_write_ready_flag)
    );

    pwm_flag_bit u_underrun (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_set(under_evt),
        .i_clr(i_status_rd),
        .o_flag(o_update_underrun_flag)
    );

    assign o_irq = (o_write_ready_flag & i_second_irq_mask[0]) | (o_update_underrun_flag & i_second_irq_mask[1]);
endmodule

// ### test_pwm_sync_auto_update.sv
// Bench: period starts, writes and a DMA model drive the block
// Expected duties are queued and compared when they appear
`timescale 1ns/10ps
module test_pwm_sync_auto_update;
    reg i_clk = 0, i_srst = 1, ps = 0, stall = 1, hold = 1, rnd = 0, go = 0, tm = 0, rd = 0, pw = 0, lw = 0;
    reg [7:0] cm = 8'h00;
    reg [15:0] pd = 16'h0000;
    reg [3:0] pc = 4'h0;
    reg [1:0] mask = 2'h0;
    reg [31:0] seed = 32'h53e1f2db;
    reg [63:0] prev = 64'h0, exq[$];
    integer num_errors = 0, checked = 0, k, r;
    time t0 = 0;
    wire dv, dr, dreq, ul, wr, ur, irq;
    wire [15:0] dd, per, dt;
    wire [63:0] duty;
    wire [3:0] upc;
    dma_duty_model dma_u (.i_clk(i_clk), .i_srst(i_srst), .i_stall(stall), .i_duty_ready(dr), .o_duty_valid(dv),
        .o_duty_data(dd));
    // Method 2, channels 0 1 3, started, processor writes
    pwm_sync_auto_update dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_sync_update_method(2'h2),
        .i_channel_sync_select(4'hb), .i_channel_zero_enable(!i_srst), .i_request_trigger_mode(tm),
        .i_request_compare_select(3'h5), .i_compare_match(cm), .i_period_start(ps), .i_period_wr(pw),
        .i_period_wdata(pd), .i_dead_time_wr(pw), .i_dead_time_wdata(~pd), .i_update_period_wr(!go),
        .i_update_period_wdata(4'h2), .i_unlock_wr(lw), .i_status_rd(rd), .i_second_irq_mask(mask),
        .i_duty_valid(dv), .i_duty_data(dd),
        .o_duty_ready(dr), .o_dma_request(dreq), .o_duty(duty), .o_period(per), .o_dead_time(dt),
        .o_update_period_count(upc), .o_update_unlock(ul), .o_write_ready_flag(wr), .o_update_underrun_flag(ur),
        .o_irq(irq));
    function [15:0] w(input integer i);
        w = 16'h1000 + i[15:0];
    endfunction
    task chk(input [63:0] seen, input [63:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task final_report;
        begin
            $display("errors %0d checks %0d", num_errors, checked);
            if (num_errors == 0 && checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task tick(input integer c);
        begin
            repeat (c) @(posedge i_clk);
            #2;
        end
    endtask
    task wait_ps;
        begin
            for (k = 0; ps !== 1'b1 && k < 40; k = k + 1) tick(1);
            if (k == 40) begin
                num_errors = num_errors + 1;
                final_report;
            end else tick(1);
        end
    endtask
    always #2.5 i_clk = !i_clk;
    always @(posedge i_clk) begin
        r = $random(seed);
        pc <= pc + 4'h1;
        ps <= go && pc == 4'hf;
        stall <= hold || (rnd && r[0]);
    end
    always @(posedge i_clk) if (!i_srst && duty !== prev) begin
        chk(duty, exq.size() ? exq.pop_front() : prev);
        if (t0) chk($time - t0, 64'hf0);
        t0 = $time;
        prev = duty;
    end
    initial begin
        for (k = 0; k < 3; k = k + 1) exq.push_back({w(3 * k + 2), 16'h0000, w(3 * k + 1), w(3 * k)});
        tick(3);
        i_srst = 0;
        tick(2);
        go = 1;
        wait_ps;
        chk({ur, wr, upc, irq}, 7'h64);
        chk(dreq, 1'b1);
        mask = 2'h2;
        tick(1);
        chk(irq, 1'b1);
        {rd, pw, hold, rnd, pd} = {4'hd, 16'h0123};
        tick(1);
        {rd, pw} = 2'h0;
        chk({ur, wr, irq, dreq}, 4'h0);
        wait_ps;
        chk(per, 16'h0000);
        lw = 1;
        tick(1);
        lw = 0;
        chk(ul, 1'b1);
        wait_ps;
        chk({ul, per, dt}, {1'b0, pd, ~pd});
        {tm, rd, cm} = {2'h3, 8'h10};
        tick(1);
        chk(wr, 1'b0);
        {rd, cm} = {1'b0, 8'h20};
        tick(1);
        cm = 8'h00;
        chk(wr, 1'b1);
        for (k = 0; exq.size() && k < 600; k = k + 1) tick(1);
        if (k == 600) num_errors = num_errors + 1;
        final_report;
    end
endmodule
